// ===== rtl/pfs_pkg.sv
// Constants for the port pin-function selection block.
// Functional notes
// - The high-byte configuration register sits at address E8 in bank 1, is read/write, covers pins 7 to 4 and resets to zero.
// - The low-byte configuration register sits at address E9 in bank 1, is read/write, covers pins 3 to 0 and resets to zero.
// - Pin 6 field 00 makes the pin a Schmitt input that also clocks a timer.
// - Pin 6 field 01 gives I2C clock, 10 is unused and 11 is output mode.
// - Low-byte fields pick, for pins 3 to 0, Schmitt input, SPI select/clock/MOSI/MISO, analog channels 13 to 10, or output.
package pfs_pkg;
    localparam logic [7:0] PFS_ADDR_CFG_HIGH = 8'hE8;
    localparam logic [7:0] PFS_ADDR_CFG_LOW  = 8'hE9;
    localparam logic [7:0] PFS_RESET_CFG     = 8'h00;
    localparam int         PFS_PINS          = 8;
    localparam int         PFS_FIELD_W       = 2;
    localparam logic [1:0] PFS_SEL_INPUT     = 2'h0;
    localparam logic [1:0] PFS_SEL_ALT       = 2'h1;
    localparam logic [1:0] PFS_SEL_ANALOG    = 2'h2;
    localparam logic [1:0] PFS_SEL_OUTPUT    = 2'h3;
    // Pins whose 10 code selects an analog channel; pins 7 and 6 leave it unused.
    localparam logic [7:0] PFS_ANALOG_PINS   = 8'h3F;
endpackage

// ===== rtl/pfs_pin_decode.sv
// Decoder of one pin's 2-bit function field.
`timescale 1ns/1ps
module pfs_pin_decode
    import pfs_pkg::*;
#(
    parameter bit HAS_ANALOG = 1'b1
) (
    input  wire logic [1:0] field,
    output logic            selInput,
    output logic            selAlt,
    output logic            selAnalog,
    output logic            selOutput
);
    always_comb begin
        selInput  = (field == PFS_SEL_INPUT);
        selAlt    = (field == PFS_SEL_ALT);
        // Code 10 on a pin without an analog channel is unused and selects nothing.
        selAnalog = HAS_ANALOG && (field == PFS_SEL_ANALOG);
        selOutput = (field == PFS_SEL_OUTPUT);
    end
endmodule

// ===== rtl/pfs_port_select.sv
// Pin-function selection for one eight-pin port, with its two configuration registers.
`timescale 1ns/1ps
module pfs_port_select
    import pfs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       regBank1,
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrite,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata,
    input  wire logic [7:0] pinIn,
    input  wire logic [7:0] portOutData,
    input  wire logic       i2cSdaOut,
    input  wire logic       i2cSclOut,
    input  wire logic       spiMisoOut,
    input  wire logic       timerTwoOut,
    input  wire logic       timerAltOut,
    output logic [7:0]      pinOut,
    output logic [7:0]      pinOutEn,
    output logic [7:0]      schmittEn,
    output logic [7:0]      analogSel,
    output logic            timerOneCapture,
    output logic            timerOneClock,
    output logic            timerTwoClock,
    output logic            timerTwoCapture,
    output logic            i2cSdaIn,
    output logic            i2cSclIn,
    output logic            spiSlaveSelect,
    output logic            spiClockIn,
    output logic            spiMosiIn,
    output logic [7:0]      cfgHigh,
    output logic [7:0]      cfgLow
);
    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers and their read-back.
    logic [7:0]  cfgHigh_ff;
    logic [7:0]  nxt_cfgHigh;
    logic [7:0]  cfgLow_ff;
    logic [7:0]  nxt_cfgLow;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;
    logic [15:0] cfgAll;
    logic [7:0]  isIn;
    logic [7:0]  isAlt;
    logic [7:0]  isAna;
    logic [7:0]  isOut;
    logic        hitHigh;
    logic        hitLow;

    // Both registers answer only in bank 1; the same addresses in bank 0 belong to other blocks.
    assign hitHigh = regBank1 && (regAddr == PFS_ADDR_CFG_HIGH);
    assign hitLow  = regBank1 && (regAddr == PFS_ADDR_CFG_LOW);

    // Read data follows the address of the previous cycle and already shows a write made in
    // that cycle, so a read straight after a write returns the new value.
    always_comb begin
        nxt_cfgHigh = cfgHigh_ff;
        nxt_cfgLow  = cfgLow_ff;
        nxt_rdata   = 8'h00;
        if (regWrite && hitHigh) begin
            nxt_cfgHigh = regWdata;
        end
        if (regWrite && hitLow) begin
            nxt_cfgLow = regWdata;
        end
        if (hitHigh) begin
            nxt_rdata = nxt_cfgHigh;
        end else if (hitLow) begin
            nxt_rdata = nxt_cfgLow;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfgHigh_ff <= PFS_RESET_CFG;
            cfgLow_ff  <= PFS_RESET_CFG;
            rdata_ff   <= 8'h00;
        end else begin
            cfgHigh_ff <= nxt_cfgHigh;
            cfgLow_ff  <= nxt_cfgLow;
            rdata_ff   <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin field decode.
    // Pin n takes bits 2n+1 and 2n of the joined bytes, so pins 7 to 4 come from the high byte.
    assign cfgAll = {cfgHigh_ff, cfgLow_ff};

    // Pins 7 and 6 have no analog channel, so their code 10 decodes to nothing and the pin floats.
    for (genvar p = 0; p < PFS_PINS; p++) begin : gPin
        pfs_pin_decode #(
            .HAS_ANALOG (PFS_ANALOG_PINS[p])
        ) uDec (
            .field     (cfgAll[PFS_FIELD_W*p +: PFS_FIELD_W]),
            .selInput  (isIn[p]),
            .selAlt    (isAlt[p]),
            .selAnalog (isAna[p]),
            .selOutput (isOut[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers and peripheral input routing.
    logic [7:0] nxt_pinOut;
    logic [7:0] nxt_pinOutEn;
    logic [7:0] nxt_inRoute;
    logic [7:0] pinOut_ff;
    logic [7:0] pinOutEn_ff;
    logic [7:0] schmitt_ff;
    logic [7:0] analog_ff;
    logic [7:0] inRoute_ff;

    // Output enable is active low. The I2C pins drive as plain outputs here; an open-drain
    // stage outside this block turns them into wired-AND lines when software enables it.
    always_comb begin
        nxt_pinOut   = portOutData;
        nxt_pinOutEn = ~isOut;
        if (isAlt[7]) begin
            nxt_pinOut[7]   = i2cSdaOut;
            nxt_pinOutEn[7] = 1'b0;
        end
        if (isAlt[6]) begin
            nxt_pinOut[6]   = i2cSclOut;
            nxt_pinOutEn[6] = 1'b0;
        end
        if (isAlt[5]) begin
            nxt_pinOut[5]   = timerAltOut;
            nxt_pinOutEn[5] = 1'b0;
        end
        if (isAlt[4]) begin
            nxt_pinOut[4]   = timerTwoOut;
            nxt_pinOutEn[4] = 1'b0;
        end
        if (isAlt[0]) begin
            nxt_pinOut[0]   = spiMisoOut;
            nxt_pinOutEn[0] = 1'b0;
        end
        // Serial inputs idle high and timer inputs idle low, so an unselected function sees no edges.
        nxt_inRoute    = 8'hFF;
        nxt_inRoute[7] = isIn[7]  ? pinIn[7] : 1'b0;
        nxt_inRoute[6] = isIn[6]  ? pinIn[6] : 1'b0;
        nxt_inRoute[5] = isIn[5]  ? pinIn[5] : 1'b0;
        nxt_inRoute[4] = isIn[4]  ? pinIn[4] : 1'b0;
        nxt_inRoute[3] = isAlt[3] ? pinIn[3] : 1'b1;
        nxt_inRoute[2] = isAlt[2] ? pinIn[2] : 1'b1;
        nxt_inRoute[1] = isAlt[1] ? pinIn[1] : 1'b1;
        // Pin 0 feeds no peripheral input; the bit only keeps the vector indexed by pin.
        nxt_inRoute[0] = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Reset leaves every pin an undriven Schmitt input, safe for whatever is wired to it.
            pinOut_ff   <= 8'h00;
            pinOutEn_ff <= 8'hFF;
            schmitt_ff  <= 8'hFF;
            analog_ff   <= 8'h00;
            inRoute_ff  <= 8'h0E;
        end else begin
            pinOut_ff   <= nxt_pinOut;
            pinOutEn_ff <= nxt_pinOutEn;
            schmitt_ff  <= isIn;
            analog_ff   <= isAna;
            inRoute_ff  <= nxt_inRoute;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // I2C receive path.
    logic sdaIn_ff;
    logic sclIn_ff;
    logic nxt_sdaIn;
    logic nxt_sclIn;

    // The I2C receivers idle high, the released level of the bus, so a pin that leaves
    // the I2C function never looks like a start condition to the controller.
    always_comb begin
        nxt_sdaIn = 1'b1;
        nxt_sclIn = 1'b1;
        if (isAlt[7]) begin
            nxt_sdaIn = pinIn[7];
        end
        if (isAlt[6]) begin
            nxt_sclIn = pinIn[6];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sdaIn_ff <= 1'b1;
            sclIn_ff <= 1'b1;
        end else begin
            sdaIn_ff <= nxt_sdaIn;
            sclIn_ff <= nxt_sclIn;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Every output is a flop, so the pins change only on the edge after their controls do.

    assign pinOut          = pinOut_ff;
    assign pinOutEn        = pinOutEn_ff;
    assign schmittEn       = schmitt_ff;
    assign analogSel       = analog_ff;
    assign timerOneCapture = inRoute_ff[7];
    assign timerOneClock   = inRoute_ff[6];
    assign timerTwoClock   = inRoute_ff[5];
    assign timerTwoCapture = inRoute_ff[4];
    assign spiSlaveSelect  = inRoute_ff[3];
    assign spiClockIn      = inRoute_ff[2];
    assign spiMosiIn       = inRoute_ff[1];
    assign i2cSdaIn        = sdaIn_ff;
    assign i2cSclIn        = sclIn_ff;
    assign regRdata        = rdata_ff;
    assign cfgHigh         = cfgHigh_ff;
    assign cfgLow          = cfgLow_ff;
endmodule

// ===== tb/pfs_port_select_sva.sv
// Assertions on the port pin-function selection block.
`timescale 1ns/1ps
module pfs_port_select_sva (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       regBank1,
    input wire logic       regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic [7:0] portOutData,
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOutEn,
    input wire logic [7:0] schmittEn,
    input wire logic [7:0] analogSel,
    input wire logic [7:0] cfgHigh,
    input wire logic [7:0] cfgLow
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    chk_high_write: assert property (regWrite && regBank1 && regAddr == 8'hE8 |=> cfgHigh == $past(regWdata))
        else $error("high write lost");
    chk_low_write: assert property (regWrite && regBank1 && regAddr == 8'hE9 |=> cfgLow == $past(regWdata))
        else $error("low write lost");
    chk_bank_gate: assert property (!regBank1 |=> $stable({cfgHigh, cfgLow}))
        else $error("write outside bank");
    chk_low_read: assert property (regBank1 && regAddr == 8'hE9 |=> regRdata == cfgLow)
        else $error("low read wrong");
    chk_pin7_out: assert property (cfgHigh[7:6] == 2'h3 |=> !pinOutEn[7] && pinOut[7] == $past(portOutData[7]))
        else $error("pin 7 not driven");
    chk_pin6_input: assert property (cfgHigh[5:4] == 2'h0 |=> schmittEn[6] && pinOutEn[6])
        else $error("pin 6 not input");
    chk_pin6_unused: assert property (cfgHigh[5:4] == 2'h2 |=> pinOutEn[6] && !schmittEn[6] && !analogSel[6])
        else $error("pin 6 unused code acts");
    chk_pin0_analog: assert property (cfgLow[1:0] == 2'h2 |=> analogSel[0] && pinOutEn[0])
        else $error("pin 0 not analog");
    cover property (regWrite && regBank1 && regAddr == 8'hE8 && regWdata == 8'hFF);
    cover property (cfgLow == 8'hAA);
    cover property (regWrite && !regBank1);
endmodule
bind pfs_port_select pfs_port_select_sva u_chk (
    .clk         (clk),
    .rst_n       (rst_n),
    .regBank1    (regBank1),
    .regWrite    (regWrite),
    .regAddr     (regAddr),
    .regWdata    (regWdata),
    .regRdata    (regRdata),
    .portOutData (portOutData),
    .pinOut      (pinOut),
    .pinOutEn    (pinOutEn),
    .schmittEn   (schmittEn),
    .analogSel   (analogSel),
    .cfgHigh     (cfgHigh),
    .cfgLow      (cfgLow)
);

// ===== tb/port3_pin_function_select_tb_top.sv
// Self-checking bench for the port pin-function selection block.
`timescale 1ns/1ps
module port3_pin_function_select_tb_top;
    import pfs_pkg::*;
    logic       clk = '0, rst_n = '0, regBank1 = '0, regWrite = '0, b;
    logic       i2cSdaOut = '0, i2cSclOut = '0, spiMisoOut = '0, timerTwoOut = '0, timerAltOut = '0;
    logic [7:0] regAddr = '0, regWdata = '0, pinIn = '0, portOutData = '0, hiM, loM, a, d, eEn, eOut;
    logic [7:0] regRdata, pinOut, pinOutEn, schmittEn, analogSel, cfgHigh, cfgLow, eSch, eAn;
    logic       timerOneCapture, timerOneClock, timerTwoClock, timerTwoCapture, i2cSdaIn, i2cSclIn;
    logic       spiSlaveSelect, spiClockIn, spiMosiIn;
    logic [8:0] eMisc;
    int         seed = 1, n_mismatch = 0, total_checks = 0, cyc = 0;
    pfs_port_select DUT (.*);
    initial forever #20 clk = ~clk;
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Only pins 7, 6, 5, 4 and 0 have a peripheral that drives them.
    function automatic void model;
        logic [15:0] c;
        logic [7:0]  alt;
        logic [1:0]  f;
        c = {hiM, loM};
        alt = {i2cSdaOut, i2cSclOut, timerAltOut, timerTwoOut, 3'h0, spiMisoOut};
        for (int n = 0; n < 8; n++) begin
            f = c[2*n +: 2];
            eEn[n] = !(f == 2'h3 || (f == 2'h1 && 8'hF1 >> n & 1));
            eOut[n] = f == 2'h3 ? portOutData[n] : alt[n];
            eSch[n] = f == 2'h0;
            eAn[n] = f == 2'h2 && n < 6;
            if (n > 3) eMisc[n + 1] = f == 2'h0 && pinIn[n];
            if (n > 5) eMisc[n - 3] = f != 2'h1 || pinIn[n];
            if (n > 0 && n < 4) eMisc[n - 1] = f != 2'h1 || pinIn[n];
        end
    endfunction
    task automatic do_reset;
        rst_n = 1'b0;
        repeat (20) @(negedge clk);
        chk({1'b0, cfgHigh}, 9'h000);
        chk({1'b0, cfgLow}, 9'h000);
        chk({1'b0, pinOutEn}, 9'h0FF);
        chk({1'b0, schmittEn}, 9'h0FF);
        chk({1'b0, analogSel}, 9'h000);
        rst_n = 1'b1;
        hiM = 8'h00;
        loM = 8'h00;
        $display("reset test done");
    endtask
    always @(posedge clk) if (++cyc == 2000) begin
        n_mismatch++;
        tally_and_finish;
    end
    initial begin
        do_reset;
        for (int i = 0; i < 300; i++) begin
            if (i == 150) do_reset;
            {pinIn, portOutData, i2cSdaOut, i2cSclOut, spiMisoOut, timerTwoOut, timerAltOut} = 21'($random(seed));
            a = i < 8 ? 8'hE8 + 8'(i % 2) : 8'hE7 + 8'($random(seed) & 3);
            d = i < 8 ? {4{2'(i / 2)}} : 8'($random(seed));
            b = i < 8 || $random(seed) % 5 != 0;
            {regBank1, regAddr, regWdata, regWrite} = {b, a, d, 1'b1};
            if (b && a == PFS_ADDR_CFG_HIGH) hiM = d;
            if (b && a == PFS_ADDR_CFG_LOW) loM = d;
            @(negedge clk);
            a = 8'hE7 + 8'($random(seed) & 3);
            b = $random(seed) % 4 != 0;
            {regBank1, regAddr, regWrite} = {b, a, 1'b0};
            @(negedge clk);
            chk({1'b0, regRdata}, {1'b0, !b ? 8'h00 : a == 8'hE8 ? hiM : a == 8'hE9 ? loM : 8'h00});
            chk({1'b0, cfgHigh}, {1'b0, hiM});
            chk({1'b0, cfgLow}, {1'b0, loM});
            model();
            chk({1'b0, pinOutEn}, {1'b0, eEn});
            chk({1'b0, pinOut | pinOutEn}, {1'b0, eOut | eEn});
            chk({1'b0, schmittEn}, {1'b0, eSch});
            chk({1'b0, analogSel}, {1'b0, eAn});
            chk({timerOneCapture, timerOneClock, timerTwoClock, timerTwoCapture, i2cSdaIn, i2cSclIn,
                 spiSlaveSelect, spiClockIn, spiMosiIn}, eMisc);
        end
        $display("random test done");
        tally_and_finish;
    end
endmodule
